/* File: spi_regs.svh */
// register offsets, field positions, reset values and counts of the serial port engine
// included by bare name; holds `define macros only
`ifndef SPI_REGS_SVH
`define SPI_REGS_SVH
// byte addresses on the apb bus, one aligned word each
`define CTRL1_OFS 8'h00
`define CTRL2_OFS 8'h04
`define BAUD_OFS 8'h08
`define STATUS_OFS 8'h0C
`define DATA_OFS 8'h10
// control register one fields
`define C1_RXIE 7
`define C1_EN 6
`define C1_TXIE 5
`define C1_MASTER_SELECT_BIT 4
`define C1_CLOCK_POLARITY_BIT 3
`define C1_CLOCK_PHASE_BIT 2
`define C1_SELECT_OUTPUT_ENABLE 1
`define C1_LSBF 0
// control register two field
`define C2_FDEN 4
// baud register fields (prescale in 6:4, divider in 2:0)
`define BR_PRE_LO 4
`define BR_DIV_LO 0
// status register fields
`define ST_RXF 7
`define ST_TXR 5
`define ST_FLT 4
// reset values
`define CTRL1_RST 8'h00
`define TXR_RST 1'b1
// sixteen serial clock edges make one byte transfer
`define XFER_EDGES 5'h10
`endif

/* File: spi_pkg.sv */
// types of the serial port engine: sequencer phase and the full state record
// assumes nothing beyond a SystemVerilog compiler
package spi_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } phase_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic fault_en;
    logic [2:0] pre;
    logic [2:0] dv;
    logic [7:0] tx_buf;
    logic tx_full;
    logic tx_room;
    logic tx_arm;
    logic [7:0] rx_buf;
    logic rx_full;
    logic rx_arm;
    logic fault;
    logic flt_arm;
    logic [7:0] shifter;
    logic sh_full;
    logic smp;
    logic [4:0] ecnt;
    logic [10:0] hc;
    phase_t ph;
    logic sclk_lvl;
    logic ss_lvl;
    logic dout;
    logic [3:0] s1;
    logic [3:0] s2;
    logic sck_prev;
    logic [31:0] prdata;
  } state_t;

endpackage : spi_pkg

/* File: spi_shift_engine.sv */
// byte-wide serial port engine with apb registers, master and slave, mode fault
// assumes spi_pkg compiled first and pins resolved outside from out/oe pairs
//
// Added by the designer: the register addresses and the APB interface to the registers.
`include "spi_regs.svh"

module spi_shift_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial clock pin
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // master out pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // master in pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // slave select pin, active low
  input wire logic ss_b_in,
  output logic ss_b_out,
  output logic ss_b_oe,
  // interrupt request
  output logic irq
);

  localparam spi_pkg::state_t RST_STATE = '{ctrl1: `CTRL1_RST, tx_room: `TXR_RST, ss_lvl: 1'b1,
                                             ph: spi_pkg::ST_IDLE, default: '0};
  // synchroniser lanes
  localparam int SCK = 3;
  localparam int SSL = 2;
  localparam int MOS = 1;
  localparam int MIS = 0;

  spi_pkg::state_t r_reg;
  spi_pkg::state_t r_next;
  logic [10:0] half;
  logic en;
  logic master;
  logic clock_phase_bit;
  logic lsbf;
  logic fault_mode;
  logic acc_rd;
  logic acc_wr;
  logic do_edge;
  logic load;
  logic finish;
  logic [7:0] rxv;

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic lsb);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction : shift_in

  // half bit period in bus cycles: prescale plus one, shifted left by the divider
  assign half = 11'((11'(r_reg.pre) + 11'd1) << r_reg.dv);
  assign en = r_reg.ctrl1[`C1_EN];
  assign master = r_reg.ctrl1[`C1_MASTER_SELECT_BIT];
  assign clock_phase_bit = r_reg.ctrl1[`C1_CLOCK_PHASE_BIT];
  assign lsbf = r_reg.ctrl1[`C1_LSBF];
  // select works as fault input only in this combination
  assign fault_mode = en && master && r_reg.fault_en && !r_reg.ctrl1[`C1_SELECT_OUTPUT_ENABLE];
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;

  // all next-state logic: bus side first, engine after so hardware sets win
  always_comb begin
    r_next = r_reg;
    do_edge = 1'b0;
    load = 1'b0;
    finish = 1'b0;
    rxv = r_reg.shifter;
    r_next.s1 = {sclk_in, ss_b_in, mosi_in, miso_in};
    r_next.s2 = r_reg.s1;
    r_next.sck_prev = r_reg.s2[SCK];
    // read data captured in setup so it is a flop in the access phase
    if (psel && !penable) begin
      case (paddr)
        `CTRL1_OFS: r_next.prdata = {24'h0000_00, r_reg.ctrl1};
        `CTRL2_OFS: r_next.prdata = {27'h000_0000, r_reg.fault_en, 4'h0};
        `BAUD_OFS: r_next.prdata = {25'h000_0000, r_reg.pre, 1'b0, r_reg.dv};
        `STATUS_OFS: r_next.prdata = {24'h0000_00, r_reg.rx_full, 1'b0, r_reg.tx_room, r_reg.fault, 4'h0};
        `DATA_OFS: r_next.prdata = {24'h0000_00, r_reg.rx_buf};
        default: r_next.prdata = 32'h0000_0000;
      endcase
    end
    // status read arms each flag that it saw set
    if (acc_rd && paddr == `STATUS_OFS) begin
      r_next.rx_arm = r_reg.prdata[`ST_RXF];
      r_next.tx_arm = r_reg.prdata[`ST_TXR];
      r_next.flt_arm = r_reg.prdata[`ST_FLT];
    end
    if (acc_rd && paddr == `DATA_OFS && r_reg.rx_arm) begin
      r_next.rx_full = 1'b0;
      r_next.rx_arm = 1'b0;
    end
    if (acc_wr) begin
      case (paddr)
        `CTRL1_OFS: begin
          r_next.ctrl1 = pwdata[7:0];
          if (r_reg.flt_arm) begin
            r_next.fault = 1'b0;
            r_next.flt_arm = 1'b0;
          end
        end
        `CTRL2_OFS: r_next.fault_en = pwdata[`C2_FDEN];
        `BAUD_OFS: begin
          r_next.pre = pwdata[`BR_PRE_LO +: 3];
          r_next.dv = pwdata[`BR_DIV_LO +: 3];
        end
        `DATA_OFS: begin
          // unarmed writes are dropped so a full buffer is never overwritten
          if (r_reg.tx_arm) begin
            r_next.tx_buf = pwdata[7:0];
            r_next.tx_full = 1'b1;
            r_next.tx_room = 1'b0;
            r_next.tx_arm = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // sequencer: master paces its own clock, slave follows the pin edges
    if (!en) begin
      r_next.ph = spi_pkg::ST_IDLE;
      r_next.ecnt = 5'h00;
      r_next.sh_full = 1'b0;
      r_next.ss_lvl = 1'b1;
      r_next.sclk_lvl = r_reg.ctrl1[`C1_CLOCK_POLARITY_BIT];
    end else if (master) begin
      case (r_reg.ph)
        spi_pkg::ST_IDLE: begin
          r_next.sclk_lvl = r_reg.ctrl1[`C1_CLOCK_POLARITY_BIT];
          r_next.ss_lvl = 1'b1;
          if (r_reg.tx_full) begin
            load = 1'b1;
            r_next.ph = spi_pkg::ST_RUN;
            r_next.ss_lvl = 1'b0;
            r_next.hc = 11'h000;
            r_next.ecnt = 5'h00;
          end
        end
        spi_pkg::ST_RUN: begin
          if (r_reg.hc == 11'(half - 11'd1)) begin
            r_next.hc = 11'h000;
            if (r_reg.ecnt < `XFER_EDGES) begin
              r_next.sclk_lvl = ~r_reg.sclk_lvl;
              r_next.ecnt = 5'(r_reg.ecnt + 5'h01);
              do_edge = 1'b1;
            end else begin
              // half a cycle after the last edge: end of bit eight
              finish = 1'b1;
              r_next.ss_lvl = 1'b1;
              r_next.ph = spi_pkg::ST_IDLE;
            end
          end else begin
            r_next.hc = 11'(r_reg.hc + 11'h001);
          end
        end
        default: r_next.ph = spi_pkg::ST_IDLE;
      endcase
    end else begin
      r_next.ph = spi_pkg::ST_IDLE;
      r_next.sclk_lvl = r_reg.ctrl1[`C1_CLOCK_POLARITY_BIT];
      r_next.ss_lvl = 1'b1;
      if (r_reg.s2[SSL]) begin
        r_next.ecnt = 5'h00;
      end else if (r_reg.s2[SCK] != r_reg.sck_prev) begin
        r_next.ecnt = 5'(r_reg.ecnt + 5'h01);
        do_edge = 1'b1;
        finish = (r_reg.ecnt == 5'(`XFER_EDGES - 5'h01));
      end
      // slave takes its byte early so the first bit sits ready at select fall
      if (!r_reg.sh_full && r_reg.ecnt == 5'h00 && r_reg.tx_full) begin
        load = 1'b1;
      end
    end
    // odd edges sample for phase 0, even edges for phase 1
    if (do_edge) begin
      if (r_next.ecnt[0] ^ clock_phase_bit) begin
        r_next.smp = master ? r_reg.s2[MIS] : r_reg.s2[MOS];
      end else if (r_next.ecnt != 5'h01 || !clock_phase_bit) begin
        r_next.shifter = shift_in(r_reg.shifter, r_reg.smp, lsbf);
      end
    end
    // phase 1 owes one last shift with the final sample
    if (finish) begin
      rxv = clock_phase_bit ? shift_in(r_reg.shifter, r_next.smp, lsbf) : r_next.shifter;
      r_next.shifter = rxv;
      r_next.sh_full = 1'b0;
      if (!master) begin
        r_next.ecnt = 5'h00;
      end
      if (!r_next.rx_full) begin
        r_next.rx_buf = rxv;
        r_next.rx_full = 1'b1;
      end // else byte lost without a flag
    end
    if (load) begin
      r_next.shifter = r_reg.tx_buf;
      r_next.tx_full = 1'b0;
      r_next.tx_room = 1'b1;
      r_next.sh_full = 1'b1;
    end
    r_next.dout = lsbf ? r_next.shifter[0] : r_next.shifter[7];
    // another master pulled select low: back off the bus at once
    if (fault_mode && !r_reg.s2[SSL]) begin
      r_next.fault = 1'b1;
      r_next.ctrl1[`C1_MASTER_SELECT_BIT] = 1'b0;
      r_next.ph = spi_pkg::ST_IDLE;
      r_next.sh_full = 1'b0;
      r_next.ecnt = 5'h00;
      r_next.ss_lvl = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  // pins and bus answers; no wait states
  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == `CTRL1_OFS || paddr == `CTRL2_OFS ||
                   paddr == `BAUD_OFS || paddr == `STATUS_OFS || paddr == `DATA_OFS);
  assign sclk_out = r_reg.sclk_lvl;
  assign sclk_oe = en && master;
  assign mosi_out = r_reg.dout;
  assign mosi_oe = en && master;
  assign miso_out = r_reg.dout;
  assign miso_oe = en && !master && !r_reg.fault && !r_reg.s2[SSL];
  assign ss_b_out = r_reg.ss_lvl;
  assign ss_b_oe = en && master && r_reg.fault_en && r_reg.ctrl1[`C1_SELECT_OUTPUT_ENABLE];
  assign irq = (r_reg.ctrl1[`C1_RXIE] && (r_reg.rx_full || r_reg.fault)) ||
               (r_reg.ctrl1[`C1_TXIE] && r_reg.tx_room);

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_take_write;
    acc_wr && paddr == `DATA_OFS && r_reg.tx_arm && en && master && !fault_mode &&
      r_reg.ph == spi_pkg::ST_IDLE && !r_reg.tx_full;
  endsequence
  sequence s_idle_master;
    (en && master && r_reg.ph == spi_pkg::ST_IDLE)[*2];
  endsequence

  property p_data_read;
    psel && !penable && !pwrite && paddr == `DATA_OFS |=> prdata[7:0] == $past(r_reg.rx_buf);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read not from receive buffer");
  property p_auto_start;
    s_take_write |-> ##[1:2] r_reg.ph == spi_pkg::ST_RUN && !ss_b_out;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("master did not start");
  property p_room_back;
    s_take_write |=> !r_reg.tx_room ##1 r_reg.tx_room;
  endproperty
  a_room_back: assert property (p_room_back) else $error("room flag late");
  property p_overrun;
    finish && r_reg.rx_full && !(acc_rd && paddr == `DATA_OFS) |=> $stable(r_reg.rx_buf) && r_reg.rx_full;
  endproperty
  a_overrun: assert property (p_overrun) else $error("old byte overwritten");
  property p_rx_set;
    finish |=> r_reg.rx_full && !r_reg.sh_full;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive full not set");
  property p_eight_bits;
    finish && master |-> r_reg.ecnt == `XFER_EDGES && $past(r_reg.sclk_lvl) == r_reg.ctrl1[`C1_CLOCK_POLARITY_BIT];
  endproperty
  a_eight_bits: assert property (p_eight_bits) else $error("transfer not sixteen edges");
  property p_idle_clk;
    s_idle_master |-> sclk_out == $past(r_reg.ctrl1[`C1_CLOCK_POLARITY_BIT]);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong");
  property p_fault;
    fault_mode && !r_reg.s2[SSL] |=> r_reg.fault && !master && !sclk_oe && !mosi_oe && !miso_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not handled");
  property p_fault_hold;
    r_reg.fault && !r_reg.flt_arm |=> r_reg.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag cleared early");
  property p_ss_rise;
    $rose(ss_b_out) && $past(r_reg.ph) == spi_pkg::ST_RUN |-> $past(r_reg.ecnt) == `XFER_EDGES;
  endproperty
  a_ss_rise: assert property (p_ss_rise) else $error("select rose mid transfer");

endmodule : spi_shift_engine

/* File: spi_peer_model.sv */
// behavioural serial slave that faces the engine while the engine is master
// assumes the bench resolves the pins and sets the clock format to match the engine
module spi_peer_model (
  // resolved pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_b,
  // clock format and bit order
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic lsb,
  // byte to send, byte seen, bytes completed
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output int n_bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  int oi = 0;
  int ns = 0;

  function automatic logic pick(input int i);
    pick = lsb ? tx_byte[i] : tx_byte[7 - i];
  endfunction : pick

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    n_bytes = 0;
  end

  // select fall: phase 0 shows the first bit at once, phase 1 waits for the first edge
  always @(negedge ss_b) begin
    oi = 0;
    ns = 0;
    if (!clock_phase_bit) begin
      miso = pick(0);
      oi = 1;
    end
  end

  // released line shows the inverse, so a stale bit never passes as data
  always @(posedge ss_b) begin
    miso = ~miso;
    if (ns == 8) begin
      rx_byte = sh;
      n_bytes = n_bytes + 1;
    end
  end

  // leading or trailing edge samples or shifts, as the phase selects
  always @(sclk) begin
    if (ss_b === 1'b0) begin
      if ((sclk !== clock_polarity_bit) ^ clock_phase_bit) begin
        sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
        ns = ns + 1;
      end else if (oi < 8) begin
        miso = pick(oi);
        oi = oi + 1;
      end
    end
  end
endmodule : spi_peer_model

/* File: spi_shift_engine_with_fault_tb_top.sv */
// self-checking bench of the serial port engine: apb master, peer slave, bench as serial master
// assumes spi_pkg, the engine and the peer model are compiled before this file
`include "spi_regs.svh"
module spi_shift_engine_with_fault_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err_seen;
  logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_b_out, ss_b_oe, irq;
  logic tb_sclk, tb_mosi, tb_ss_b, peer_miso, clock_polarity_bit, clock_phase_bit, lsb;
  logic [7:0] paddr, peer_tx, peer_rx;
  logic [31:0] pwdata, prdata, rd_val;
  int peer_n, cyc = 0, error_cnt = 0, samples_checked = 0;
  // pin levels resolved from the engine's enables; bench or peer drives otherwise
  wire logic sclk_w = sclk_oe ? sclk_out : tb_sclk;
  wire logic mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire logic miso_w = miso_oe ? miso_out : peer_miso;
  wire logic ss_w = ss_b_oe ? ss_b_out : tb_ss_b;

  spi_shift_engine i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_b_in(ss_w), .ss_b_out(ss_b_out),
    .ss_b_oe(ss_b_oe), .irq(irq));
  spi_peer_model i_peer (.sclk(sclk_w), .mosi(mosi_w), .ss_b(ss_w), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .lsb(lsb),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx), .n_bytes(peer_n));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // whole run needs about 1000 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; zero wait states are not assumed, pready is awaited
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_val = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd_val);
  endtask : rd_chk

  task automatic wait_peer(input int n);
    repeat (3000) if (peer_n < n) @(posedge ref_clk);
    chk("peer count", n, peer_n);
  endtask : wait_peer

  task automatic s_reset();
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    rd_chk("ctrl1", `CTRL1_OFS, 32'h0000_0000);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, err_seen});
  endtask : s_reset

  // one master byte in format {polarity, phase, lsb first}
  task automatic s_master(input logic [2:0] fmt, input logic [7:0] tx, input logic [7:0] prx);
    int n;
    n = peer_n;
    {clock_polarity_bit, clock_phase_bit, lsb} <= fmt;
    peer_tx <= prx;
    apb(1'b1, `CTRL1_OFS, {24'h00_0000, 4'hd, fmt[2:1], 1'b1, fmt[0]});
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    apb(1'b1, `DATA_OFS, {24'h00_0000, tx});
    wait_peer(n + 1);
    repeat (4) @(posedge ref_clk);
    chk("peer rx", tx, peer_rx);
    chk("irq", 32'h0000_0001, irq);
    chk("idle clock", clock_polarity_bit, sclk_w);
    rd_chk("status", `STATUS_OFS, 32'h0000_00a0);
    rd_chk("data", `DATA_OFS, prx);
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    chk("irq", 32'h0000_0000, irq);
  endtask : s_master

  // queued byte, unread buffer and a write without a status read
  task automatic s_overrun();
    int n;
    n = peer_n;
    peer_tx <= 8'h33;
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    apb(1'b1, `DATA_OFS, 32'h0000_0011);
    @(posedge ref_clk);
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    apb(1'b1, `DATA_OFS, 32'h0000_0022);
    wait_peer(n + 1);
    peer_tx <= 8'h44;
    chk("peer rx", 32'h0000_0011, peer_rx);
    wait_peer(n + 2);
    chk("peer rx", 32'h0000_0022, peer_rx);
    apb(1'b1, `DATA_OFS, 32'h0000_0055);
    repeat (300) @(posedge ref_clk);
    chk("peer count", n + 2, peer_n);
    rd_chk("status", `STATUS_OFS, 32'h0000_00a0);
    rd_chk("data", `DATA_OFS, 32'h0000_0033);
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
  endtask : s_overrun

  task automatic s_fault();
    apb(1'b1, `CTRL1_OFS, 32'h0000_0050);
    tb_ss_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("drivers off", 32'h0000_0000, {sclk_oe, mosi_oe, miso_oe});
    rd_chk("ctrl1", `CTRL1_OFS, 32'h0000_0040);
    tb_ss_b <= 1'b1;
    apb(1'b1, `CTRL1_OFS, 32'h0000_0040);
    rd_chk("status", `STATUS_OFS, 32'h0000_0030);
    apb(1'b1, `CTRL1_OFS, 32'h0000_0040);
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    // transmit mask on with room shown must raise the request
    apb(1'b1, `CTRL1_OFS, 32'h0000_0060);
    @(posedge ref_clk);
    chk("irq", 32'h0000_0001, irq);
  endtask : s_fault

  // engine as slave, bench as master with a 400 ns link clock
  task automatic s_slave();
    logic [7:0] sb, got;
    sb = 8'hc3;
    got = 8'h00;
    rd_chk("status", `STATUS_OFS, 32'h0000_0020);
    apb(1'b1, `DATA_OFS, 32'h0000_005a);
    tb_ss_b <= 1'b0;
    tb_mosi <= sb[7];
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(posedge ref_clk);
      if (i % 2 == 0) begin
        got = {got[6:0], miso_w};
      end else begin
        sb = sb << 1;
        tb_mosi <= sb[7];
      end
      tb_sclk <= ~tb_sclk;
    end
    repeat (4) @(posedge ref_clk);
    tb_ss_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("slave out", 32'h0000_005a, got);
    rd_chk("status", `STATUS_OFS, 32'h0000_00a0);
    rd_chk("data", `DATA_OFS, 32'h0000_00c3);
  endtask : s_slave

  initial begin
    logic [2:0] fmts[4] = '{3'b000, 3'b101, 3'b110, 3'b011};
    {rst_b, psel, penable, pwrite, tb_sclk, tb_mosi, clock_polarity_bit, clock_phase_bit, lsb} = '0;
    tb_ss_b = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    peer_tx = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    s_reset();
    apb(1'b1, `BAUD_OFS, 32'h0000_0011);
    apb(1'b1, `CTRL2_OFS, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      s_master(fmts[i], 8'h81 + 8'(i), 8'h1d ^ 8'(i));
    end
    s_overrun();
    s_fault();
    s_slave();
    final_report();
  end
endmodule : spi_shift_engine_with_fault_tb_top
